// *** ccrf_pkg.sv ***
// package: constants for the core register set and flags word
package ccrf_pkg;
    localparam int CCRF_DW = 8;
    localparam int CCRF_PW = 16;
    localparam int CCRF_BIT_H = 4;
    localparam int CCRF_BIT_N = 2;
    localparam int CCRF_BIT_Z = 1;
    localparam int CCRF_BIT_C = 0;
    localparam int CCRF_BIT_PU = 5;
    localparam int CCRF_BIT_PL = 3;
    localparam int CCRF_BIT_MSB = 7;
    localparam logic [7:0] CCRF_FLAGS_RST = 8'hE8;
    localparam logic [7:0] CCRF_FIXED_MASK = 8'hC0;
    localparam logic [7:0] CCRF_ZERO8 = 8'h00;
    localparam logic [15:0] CCRF_ZERO16 = 16'h0000;
    localparam logic [1:0] CCRF_LVL0 = 2'h2;
    localparam logic [1:0] CCRF_LVL1 = 2'h1;
    localparam logic [1:0] CCRF_LVL2 = 2'h0;
    localparam logic [1:0] CCRF_LVL3 = 2'h3;
    // register selects for dedicated-instruction write and read ports
    typedef enum logic [2:0] {
        CCRF_SEL_ACC = 3'h0,
        CCRF_SEL_IDX1 = 3'h1,
        CCRF_SEL_IDX2 = 3'h2,
        CCRF_SEL_PTRL = 3'h3,
        CCRF_SEL_PTRH = 3'h4,
        CCRF_SEL_FLAGS = 3'h5
    } ccrf_sel_t;
    // flag update operations from the alu
    typedef enum logic [2:0] {
        CCRF_OP_NONE = 3'h0,
        CCRF_OP_ADD = 3'h1,
        CCRF_OP_ARITH = 3'h2,
        CCRF_OP_LOGIC = 3'h3,
        CCRF_OP_CARRY = 3'h4
    } ccrf_op_t;
endpackage

// *** ccrf_reg8.sv ***
// file: one 8-bit loadable register with reset value
`timescale 1ns/1ps
module ccrf_reg8 #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= RST;
        end else if (load) begin
            q <= d;
        end
    end
endmodule

// *** ccrf_core_regs.sv ***
// file: programmer-visible core registers and flags word
`timescale 1ns/1ps
module ccrf_core_regs
    import ccrf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_sel,
    output logic [7:0] rd_data,
    input wire logic ptr_load,
    input wire logic [15:0] ptr_data,
    input wire logic [2:0] flag_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic alu_cin,
    input wire logic [7:0] alu_res,
    input wire logic alu_cout,
    input wire logic set_carry_op,
    input wire logic clear_carry_op,
    input wire logic irq_entry,
    input wire logic [1:0] irq_priority_regs,
    input wire logic prio_sw_load,
    input wire logic [1:0] prio_sw_val,
    input wire logic irq_enable_op,
    input wire logic irq_disable_op,
    input wire logic ctx_restore,
    input wire logic [7:0] ctx_flags,
    input wire logic [7:0] ctx_acc,
    input wire logic [7:0] ctx_idx1,
    input wire logic [15:0] ctx_ptr,
    output logic [7:0] acc,
    output logic [7:0] idx1,
    output logic [7:0] idx2,
    output logic [15:0] instruction_pointer,
    output logic [7:0] flags_word,
    output logic [1:0] prio_level
);
    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    // note: no memory address decode exists here at all
    logic acc_ld, idx1_ld, idx2_ld, pl_ld, ph_ld;
    logic [7:0] acc_d, idx1_d, pl_d, ph_d;
    logic [7:0] instr_ptr_low, instr_ptr_high;

    assign acc_ld = ctx_restore | (wr_en && wr_sel == CCRF_SEL_ACC);
    assign acc_d = ctx_restore ? ctx_acc : wr_data;
    assign idx1_ld = ctx_restore | (wr_en && wr_sel == CCRF_SEL_IDX1);
    assign idx1_d = ctx_restore ? ctx_idx1 : wr_data;
    // second index ignores context restore so handlers leave it alone
    assign idx2_ld = wr_en && wr_sel == CCRF_SEL_IDX2;
    assign pl_ld = ctx_restore | ptr_load | (wr_en && wr_sel == CCRF_SEL_PTRL);
    assign ph_ld = ctx_restore | ptr_load | (wr_en && wr_sel == CCRF_SEL_PTRH);
    assign pl_d = ctx_restore ? ctx_ptr[7:0] : (ptr_load ? ptr_data[7:0] : wr_data);
    assign ph_d = ctx_restore ? ctx_ptr[15:8] : (ptr_load ? ptr_data[15:8] : wr_data);

    ccrf_reg8 #(.W(CCRF_DW), .RST(CCRF_ZERO8)) u_acc (.mclk(mclk), .rst_n(rst_n),
        .load(acc_ld), .d(acc_d), .q(acc));
    ccrf_reg8 #(.W(CCRF_DW), .RST(CCRF_ZERO8)) u_idx1 (.mclk(mclk), .rst_n(rst_n),
        .load(idx1_ld), .d(idx1_d), .q(idx1));
    ccrf_reg8 #(.W(CCRF_DW), .RST(CCRF_ZERO8)) u_idx2 (.mclk(mclk), .rst_n(rst_n),
        .load(idx2_ld), .d(wr_data), .q(idx2));
    ccrf_reg8 #(.W(CCRF_DW), .RST(CCRF_ZERO8)) u_pl (.mclk(mclk), .rst_n(rst_n),
        .load(pl_ld), .d(pl_d), .q(instr_ptr_low));
    ccrf_reg8 #(.W(CCRF_DW), .RST(CCRF_ZERO8)) u_ph (.mclk(mclk), .rst_n(rst_n),
        .load(ph_ld), .d(ph_d), .q(instr_ptr_high));

    assign instruction_pointer = {instr_ptr_high, instr_ptr_low};

    // ------------------------------------------------------------
    // flags word
    // ------------------------------------------------------------
    logic [7:0] flags_r, flags_nxt;
    logic [4:0] low_sum;
    logic half_c;

    // carry out of bit 3 recomputed from operands
    assign low_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
    assign half_c = low_sum[4];

    always_comb begin
        flags_nxt = flags_r;
        if (wr_en && wr_sel == CCRF_SEL_FLAGS) begin
            flags_nxt = wr_data;
        end else if (ctx_restore) begin
            flags_nxt = ctx_flags;
        end
        case (flag_op)
            CCRF_OP_ADD: begin
                flags_nxt[CCRF_BIT_H] = half_c;
                flags_nxt[CCRF_BIT_N] = alu_res[CCRF_BIT_MSB];
                flags_nxt[CCRF_BIT_Z] = (alu_res == CCRF_ZERO8);
                flags_nxt[CCRF_BIT_C] = alu_cout;
            end
            CCRF_OP_ARITH: begin
                flags_nxt[CCRF_BIT_N] = alu_res[CCRF_BIT_MSB];
                flags_nxt[CCRF_BIT_Z] = (alu_res == CCRF_ZERO8);
                flags_nxt[CCRF_BIT_C] = alu_cout;
            end
            CCRF_OP_LOGIC: begin
                flags_nxt[CCRF_BIT_N] = alu_res[CCRF_BIT_MSB];
                flags_nxt[CCRF_BIT_Z] = (alu_res == CCRF_ZERO8);
            end
            CCRF_OP_CARRY: begin
                // bit test, shift and rotate touch carry only here
                flags_nxt[CCRF_BIT_C] = alu_cout;
            end
            default: begin
            end
        endcase
        if (set_carry_op) begin
            flags_nxt[CCRF_BIT_C] = 1'b1;
        end else if (clear_carry_op) begin
            flags_nxt[CCRF_BIT_C] = 1'b0;
        end
        // priority: entry beats software, disable beats enable
        if (irq_entry) begin
            {flags_nxt[CCRF_BIT_PU], flags_nxt[CCRF_BIT_PL]} = irq_priority_regs;
        end else if (irq_disable_op) begin
            {flags_nxt[CCRF_BIT_PU], flags_nxt[CCRF_BIT_PL]} = CCRF_LVL3;
        end else if (irq_enable_op) begin
            {flags_nxt[CCRF_BIT_PU], flags_nxt[CCRF_BIT_PL]} = CCRF_LVL0;
        end else if (prio_sw_load) begin
            {flags_nxt[CCRF_BIT_PU], flags_nxt[CCRF_BIT_PL]} = prio_sw_val;
        end
        flags_nxt = flags_nxt | CCRF_FIXED_MASK;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags_r <= CCRF_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_word = flags_r;
    assign prio_level = {flags_r[CCRF_BIT_PU], flags_r[CCRF_BIT_PL]};

    // ------------------------------------------------------------
    // dedicated read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data <= CCRF_ZERO8;
        end else begin
            case (rd_sel)
                CCRF_SEL_ACC: rd_data <= acc;
                CCRF_SEL_IDX1: rd_data <= idx1;
                CCRF_SEL_IDX2: rd_data <= idx2;
                CCRF_SEL_PTRL: rd_data <= instr_ptr_low;
                CCRF_SEL_PTRH: rd_data <= instr_ptr_high;
                CCRF_SEL_FLAGS: rd_data <= flags_r;
                default: rd_data <= CCRF_ZERO8;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_fixed_bits_one: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 ((flags_r & CCRF_FIXED_MASK) == CCRF_FIXED_MASK))
        else $error("fixed flag bits not one");
    a_reset_flags: assert property (@(posedge mclk)
        !rst_n |=> (flags_r == CCRF_FLAGS_RST)) else $error("flags reset wrong");
    a_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag_op == CCRF_OP_LOGIC && !(wr_en && wr_sel == CCRF_SEL_FLAGS))
        |=> flags_r[CCRF_BIT_Z] == ($past(alu_res) == CCRF_ZERO8))
        else $error("zero flag wrong");
    a_sign_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag_op inside {CCRF_OP_ADD, CCRF_OP_ARITH, CCRF_OP_LOGIC})
        |=> flags_r[CCRF_BIT_N] == $past(alu_res[CCRF_BIT_MSB]))
        else $error("sign flag wrong");
    // carry into bit 4 rebuilt from the sum, independent of the nibble adder above
    a_half_carry: assert property (@(posedge mclk) disable iff (!rst_n)
        flag_op == CCRF_OP_ADD |=> flags_r[CCRF_BIT_H] ==
        $past(alu_res[CCRF_BIT_H] ^ alu_a[CCRF_BIT_H] ^ alu_b[CCRF_BIT_H]))
        else $error("half carry wrong");
    a_carry_set: assert property (@(posedge mclk) disable iff (!rst_n)
        set_carry_op |=> flags_r[CCRF_BIT_C]) else $error("carry set lost");
    a_carry_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (clear_carry_op && !set_carry_op) |=> !flags_r[CCRF_BIT_C])
        else $error("carry clear lost");
    a_carry_ovf: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag_op == CCRF_OP_ARITH && !set_carry_op && !clear_carry_op)
        |=> flags_r[CCRF_BIT_C] == $past(alu_cout)) else $error("carry flag wrong");
    a_add_carry: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag_op == CCRF_OP_ADD && !set_carry_op && !clear_carry_op)
        |=> flags_r[CCRF_BIT_C] == $past(alu_cout)) else $error("add carry wrong");
    a_irq_prio: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_entry |=> prio_level == $past(irq_priority_regs))
        else $error("entry priority wrong");
    a_sim_prio: assert property (@(posedge mclk) disable iff (!rst_n)
        (irq_disable_op && !irq_entry) |=> prio_level == CCRF_LVL3)
        else $error("disable priority wrong");
    a_enable_prio: assert property (@(posedge mclk) disable iff (!rst_n)
        (irq_enable_op && !irq_entry && !irq_disable_op) |=> prio_level == CCRF_LVL0)
        else $error("enable priority wrong");
    a_idx2_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctx_restore && !(wr_en && wr_sel == CCRF_SEL_IDX2)) |=> $stable(idx2))
        else $error("second index changed by restore");
    a_idx2_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && wr_sel == CCRF_SEL_IDX2) |=> idx2 == $past(wr_data))
        else $error("second index write wrong");
    a_acc_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && wr_sel == CCRF_SEL_ACC && !ctx_restore) |=> acc == $past(wr_data))
        else $error("accumulator write wrong");
    a_ptr_load: assert property (@(posedge mclk) disable iff (!rst_n)
        (ptr_load && !ctx_restore) |=> instruction_pointer == $past(ptr_data))
        else $error("pointer load wrong");
    a_read_flags: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_sel == CCRF_SEL_FLAGS) |=> rd_data == $past(flags_r))
        else $error("flags read wrong");
endmodule

// *** ccrf_alu_model.sv ***
// partner model: adder of the alu that feeds the flags logic
`timescale 1ns/1ps
module ccrf_alu_model
    import ccrf_pkg::*;
(
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] res,
    output logic cout
);
    // plain sum only; the half carry is left for the flags logic to work out
    assign {cout, res} = {1'b0, a} + {1'b0, b} + {8'h00, cin};
endmodule

// *** tb_ccrf_core_regs.sv ***
// testbench: random and corner stimulus for the core register set
`timescale 1ns/1ps
module tb_ccrf_core_regs;
    import ccrf_pkg::*;
    // ----
    // signals
    // ----
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en, ptr_load, alu_cin, set_carry_op, clear_carry_op, irq_entry, alu_cout;
    logic prio_sw_load, irq_enable_op, irq_disable_op, ctx_restore, c;
    logic [2:0] wr_sel, rd_sel, flag_op, sel;
    logic [1:0] irq_priority_regs, prio_sw_val, prio_level, e2;
    logic [7:0] wr_data, alu_a, alu_b, ctx_flags, ctx_acc, ctx_idx1, alu_res, rd_data;
    logic [7:0] acc, idx1, idx2, flags_word, mf, mi2, d, a, b;
    logic [15:0] ptr_data, ctx_ptr, instruction_pointer, p;
    logic [1:0] lv [4] = '{CCRF_LVL0, CCRF_LVL1, CCRF_LVL2, CCRF_LVL3};
    integer seed = 32'h0fdc;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    always #12.5 mclk = ~mclk;
    ccrf_alu_model u_ccrf_alu_model (.a(alu_a), .b(alu_b), .cin(alu_cin), .res(alu_res),
        .cout(alu_cout));
    ccrf_core_regs u_ccrf_core_regs (.mclk, .rst_n, .wr_en, .wr_sel, .wr_data, .rd_sel,
        .rd_data, .ptr_load, .ptr_data, .flag_op, .alu_a, .alu_b, .alu_cin, .alu_res,
        .alu_cout, .set_carry_op, .clear_carry_op, .irq_entry, .irq_priority_regs,
        .prio_sw_load, .prio_sw_val, .irq_enable_op, .irq_disable_op, .ctx_restore,
        .ctx_flags, .ctx_acc, .ctx_idx1, .ctx_ptr, .acc, .idx1, .idx2, .instruction_pointer,
        .flags_word, .prio_level);
    // ----
    // helpers
    // ----
    function automatic logic [7:0] exp_op(input logic [2:0] op, input logic [7:0] f, x, y,
        input logic ci);
        logic [8:0] s;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        exp_op = f;
        if (op == CCRF_OP_ADD) exp_op[4] = ({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci}) > 5'h0f;
        if (op != CCRF_OP_CARRY) exp_op[2:1] = {s[7], s[7:0] == 8'h00};
        if (op != CCRF_OP_LOGIC) exp_op[0] = s[8];
    endfunction
    function logic [7:0] port_of(input logic [2:0] s);
        logic [7:0] v [6];
        v = '{acc, idx1, idx2, instruction_pointer[7:0], instruction_pointer[15:8], flags_word};
        return v[s];
    endfunction
    task automatic idle();
        {wr_en, ptr_load, set_carry_op, clear_carry_op, irq_entry, prio_sw_load} <= '0;
        {irq_enable_op, irq_disable_op, ctx_restore, flag_op} <= '0;
    endtask
    // requests are set after one edge, taken at the next, then dropped
    task automatic fire();
        @(posedge mclk);
        idle();
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] e, s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end
    // ----
    // stimulus
    // ----
    initial begin
        idle();
        {wr_sel, rd_sel, wr_data, alu_a, alu_b, alu_cin, irq_priority_regs, prio_sw_val} <= '0;
        {ptr_data, ctx_flags, ctx_acc, ctx_idx1, ctx_ptr} <= '0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        mf = CCRF_FLAGS_RST;
        mi2 = 8'h00;
        chk("flags", mf, flags_word);
        chk("regs", 16'h0000, {acc, idx1});
        chk("idx2 rd_data", 16'h0000, {idx2, rd_data});
        chk("ptr", 16'h0000, instruction_pointer);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            sel = i < 6 ? 3'(i) : 3'($unsigned($random(seed)) % 6);
            d = i == 5 ? 8'h00 : 8'($random(seed));
            @(posedge mclk);
            {wr_en, wr_sel, wr_data, rd_sel} <= {1'b1, sel, d, sel};
            fire();
            @(posedge mclk);
            #1;
            if (sel == CCRF_SEL_FLAGS) d = d | CCRF_FIXED_MASK;
            if (sel == CCRF_SEL_FLAGS) mf = d;
            if (sel == CCRF_SEL_IDX2) mi2 = d;
            chk("port", d, port_of(sel));
            chk("rd_data", d, rd_data);
        end
        @(posedge mclk);
        rd_sel <= 3'h6;
        @(posedge mclk);
        @(posedge mclk);
        #1;
        chk("rd_data", 16'h0000, rd_data);
        p = 16'($random(seed));
        @(posedge mclk);
        {ptr_load, ptr_data} <= {1'b1, p};
        fire();
        chk("ptr", p, instruction_pointer);
        $display("test writes done");
        for (int i = 0; i < 40; i++) begin
            a = i == 0 ? 8'h_0f : (i == 1 ? 8'h_ff : 8'($random(seed)));
            b = i < 2 ? 8'h_01 : 8'($random(seed));
            c = i < 2 ? 1'b0 : 1'($random(seed));
            @(posedge mclk);
            {flag_op, alu_a, alu_b, alu_cin} <= {3'(1 + i % 4), a, b, c};
            fire();
            mf = exp_op(3'(1 + i % 4), mf, a, b, c);
            chk("flags op", mf, flags_word);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            {set_carry_op, clear_carry_op} <= {i != 1, i != 0};
            fire();
            mf[0] = i != 1;
            chk("carry", mf, flags_word);
        end
        $display("test flags done");
        for (int i = 0; i < 7; i++) begin
            e2 = i < 4 ? lv[i] : (i == 4 ? CCRF_LVL3 : (i == 5 ? CCRF_LVL0 : lv[1]));
            @(posedge mclk);
            {irq_entry, irq_priority_regs, prio_sw_load} <= {i < 4, e2, 1'b1};
            // in the first six steps the software value differs from the target so the priority order is exercised; the last step loads the target itself
            prio_sw_val <= i < 6 ? ~e2 : e2;
            {irq_disable_op, irq_enable_op} <= {i == 4, i == 5};
            fire();
            {mf[5], mf[3]} = e2;
            chk("prio", e2, prio_level);
            chk("flags prio", mf, flags_word);
        end
        {d, a, b, p} = 40'({$random(seed), $random(seed)});
        @(posedge mclk);
        {ctx_restore, ctx_flags, ctx_acc, ctx_idx1, ctx_ptr} <= {1'b1, d, a, b, p};
        fire();
        chk("ctx flags", d | CCRF_FIXED_MASK, flags_word);
        chk("ctx regs", {a, b}, {acc, idx1});
        chk("ctx ptr", p, instruction_pointer);
        chk("idx2", mi2, idx2);
        $display("test priority and context done");
        print_verdict();
    end
endmodule
